// >>> verilog/cgs_pkg.sv
// Package for the codec gain sub-register bank: slot layout, prefixes, defaults.
// Assumes a single 40 MHz clock and an AXI4-Lite register port.
package cgs_pkg;
  // --------------------------------------------------------------------
  // Bus
  // --------------------------------------------------------------------
  localparam int          ADDR_W         = 4;
  localparam logic [3:0]  SLOT_ADDR      = 4'h0;
  localparam logic [3:0]  STATUS_ADDR    = 4'h4;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;
  // --------------------------------------------------------------------
  // Slot byte layout
  // --------------------------------------------------------------------
  localparam int          PFX_HI         = 7;
  localparam int          PFX_LO         = 6;
  localparam int          STG_HI         = 5;
  localparam int          STG_LO         = 3;
  localparam int          RSV_BIT        = 2;
  localparam int          INPUT_BUFFER_GAIN_CODE_HI        = 1;
  localparam int          INPUT_BUFFER_GAIN_CODE_LO        = 0;
  localparam logic [1:0]  PFX_ADC        = 2'b00;
  localparam logic [1:0]  PFX_DAC        = 2'b01;
  localparam logic [1:0]  PFX_STB        = 2'b10;
  localparam logic [1:0]  PFX_VER        = 2'b11;
  // --------------------------------------------------------------------
  // Reset values and codes
  // --------------------------------------------------------------------
  localparam logic [5:0]  GAIN_RESET     = 6'h2a;
  localparam logic [5:0]  GAIN_MUTE      = 6'h3f;
  localparam logic [2:0]  STG_RESET      = 3'h7;
  localparam logic [1:0]  INPUT_BUFFER_GAIN_CODE_RESET     = 2'h0;
  // Version identifier; value is arbitrary
  localparam logic [5:0]  VERSION_ID     = 6'h15;
  // Read sequence phase
  typedef enum logic [1:0] {
    CGS_RD_ADC = 2'b00,
    CGS_RD_DAC = 2'b01,
    CGS_RD_STB = 2'b10,
    CGS_RD_VER = 2'b11
  } cgs_rd_t;
endpackage : cgs_pkg

// >>> verilog/cgs_decode.sv
// Gain decoder: turns stored codes into dB settings (signed for DAC and sidetone, unsigned for input buffer) and mute flags.
// Assumes codes come from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cgs_decode (
  input  wire logic [5:0] dac_gain_code,
  input  wire logic [2:0] sidetone_gain_code,
  input  wire logic [1:0] input_buffer_gain_code,
  output logic            dac_mute,
  output logic signed [7:0] dac_gain_db,
  output logic            sidetone_mute,
  output logic signed [7:0] sidetone_gain_db,
  output logic [7:0]      input_buffer_gain_db
);
  import cgs_pkg::*;
  // --------------------------------------------------------------------
  // Decoding
  // --------------------------------------------------------------------
  always_comb begin
    dac_mute    = (dac_gain_code == GAIN_MUTE);
    dac_gain_db = 8'(signed'({2'b00, dac_gain_code}) - 8'sd42);
    sidetone_mute    = (sidetone_gain_code == STG_RESET);
    sidetone_gain_db = 8'(-8'sd3 - 8'sd3 * signed'({5'b0, sidetone_gain_code}));
    case (input_buffer_gain_code)
      2'b11:   input_buffer_gain_db = 8'd24;
      2'b10:   input_buffer_gain_db = 8'd12;
      2'b01:   input_buffer_gain_db = 8'd6;
      default: input_buffer_gain_db = 8'd0;
    endcase
  end
endmodule : cgs_decode
`default_nettype wire

// >>> verilog/cgs_regs.sv
// Codec gain sub-register bank behind an AXI4-Lite slave.
// Assumes one clock aclk at 40 MHz and synchronous active-low reset.
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cgs_regs (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [cgs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [cgs_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic [5:0]                adc_gain_code,
  output logic [5:0]                dac_gain_code,
  output logic [2:0]                sidetone_gain_code,
  output logic [1:0]                input_buffer_gain_code,
  output logic                      dac_mute,
  output logic signed [7:0]         dac_gain_db,
  output logic                      sidetone_mute,
  output logic signed [7:0]         sidetone_gain_db,
  output logic [7:0]                input_buffer_gain_db
);
  import cgs_pkg::*;

  // --------------------------------------------------------------------
  // Write channel capture
  // --------------------------------------------------------------------
  logic                  aw_held;
  logic [ADDR_W-1:0]     aw_addr;
  logic                  w_held;
  logic [7:0]            w_byte;
  logic                  w_lane0;
  logic                  wr_fire;
  cgs_rd_t               rd_phase;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held  <= 1'b0;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held  <= 1'b1;
      w_byte  <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr == SLOT_ADDR || aw_addr == STATUS_ADDR) ? RESP_OKAY
                                                                        : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Sub-register storage
  // --------------------------------------------------------------------
  logic slot_wr;
  assign slot_wr = wr_fire && w_lane0 && (aw_addr == SLOT_ADDR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adc_gain_code <= GAIN_RESET;
    end else if (slot_wr && w_byte[PFX_HI:PFX_LO] == PFX_ADC) begin
      adc_gain_code <= w_byte[5:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_gain_code <= GAIN_RESET;
    end else if (slot_wr && w_byte[PFX_HI:PFX_LO] == PFX_DAC) begin
      dac_gain_code <= w_byte[5:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sidetone_gain_code     <= STG_RESET;
      input_buffer_gain_code <= INPUT_BUFFER_GAIN_CODE_RESET;
    end else if (slot_wr && w_byte[PFX_HI:PFX_LO] == PFX_STB) begin
      sidetone_gain_code     <= w_byte[STG_HI:STG_LO];
      input_buffer_gain_code <= w_byte[INPUT_BUFFER_GAIN_CODE_HI:INPUT_BUFFER_GAIN_CODE_LO];
    end
  end
  // Prefix 11 writes change nothing: identifier is read-only

  // --------------------------------------------------------------------
  // Read channel and slot read sequence
  // --------------------------------------------------------------------
  logic [7:0] slot_byte;
  logic       rd_fire;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;

  always_comb begin
    case (rd_phase)
      CGS_RD_ADC: slot_byte = {PFX_ADC, adc_gain_code};
      CGS_RD_DAC: slot_byte = {PFX_DAC, dac_gain_code};
      CGS_RD_STB: slot_byte = {PFX_STB, sidetone_gain_code, 1'b0,
                               input_buffer_gain_code};
      CGS_RD_VER: slot_byte = {PFX_VER, VERSION_ID};
      default:    slot_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_phase <= CGS_RD_ADC;
    end else if (rd_fire && s_axi_araddr == SLOT_ADDR) begin
      rd_phase <= cgs_rd_t'(2'(rd_phase + 2'd1));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      if (s_axi_araddr == SLOT_ADDR) begin
        s_axi_rdata <= {24'h000000, slot_byte};
      end else if (s_axi_araddr == STATUS_ADDR) begin
        s_axi_rdata <= {30'h0, rd_phase};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Gain decoding
  // --------------------------------------------------------------------
  cgs_decode u_decode (
    .dac_gain_code          (dac_gain_code),
    .sidetone_gain_code     (sidetone_gain_code),
    .input_buffer_gain_code (input_buffer_gain_code),
    .dac_mute               (dac_mute),
    .dac_gain_db            (dac_gain_db),
    .sidetone_mute          (sidetone_mute),
    .sidetone_gain_db       (sidetone_gain_db),
    .input_buffer_gain_db   (input_buffer_gain_db)
  );

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_dac_store: assert property (slot_wr && w_byte[7:6] == 2'b01 |=>
    dac_gain_code == $past(w_byte[5:0])) else $error("dac code not stored");
  chk_dac_reset: assert property ($rose(aresetn) |-> dac_gain_code == 6'h2a)
    else $error("dac code reset wrong");
  chk_read_order: assert property (rd_fire && araddr_slot() |=>
    s_axi_rdata[7:6] == $past(rd_phase)) else $error("read order wrong");
  chk_dac_decode: assert property (!dac_mute |->
    dac_gain_db == 8'sd20 - $signed(8'(6'h3e - dac_gain_code))) else $error("dac db wrong");
  chk_stg_decode: assert property (!sidetone_mute |->
    sidetone_gain_db == -8'sd21 + 8'sd3 * $signed(8'(3'h6 - sidetone_gain_code)))
    else $error("sidetone db wrong");
  chk_input_buffer_gain_code_decode: assert property (input_buffer_gain_code == 2'b11 |->
    input_buffer_gain_db == 8'd24) else $error("buffer db wrong");
  chk_ver_fixed: assert property (s_axi_rvalid && $past(rd_fire) &&
    $past(rd_phase) == CGS_RD_VER && $past(araddr_slot()) |->
    s_axi_rdata[7:0] == {2'b11, VERSION_ID}) else $error("version wrong");
  chk_adc_store: assert property (slot_wr && w_byte[7:6] == 2'b00 |=>
    adc_gain_code == $past(w_byte[5:0]) && $stable(dac_gain_code))
    else $error("adc write wrong");
  chk_rsv_zero: assert property (s_axi_rvalid && $past(rd_fire) &&
    $past(rd_phase) == CGS_RD_STB && $past(araddr_slot()) |->
    s_axi_rdata[2] == 1'b0) else $error("reserved bit set");

  cov_dac_write: cover property (slot_wr && w_byte[7:6] == 2'b01);
  cov_four_reads: cover property (rd_fire && araddr_slot() && rd_phase == CGS_RD_VER);
  cov_stb_write: cover property (slot_wr && w_byte[7:6] == 2'b10);

  function automatic logic araddr_slot();
    return s_axi_araddr == SLOT_ADDR;
  endfunction : araddr_slot
endmodule : cgs_regs
`default_nettype wire

// >>> testbench/cgs_regs_test.sv
// Self-checking bench for the codec gain sub-register bank.
// Assumes cgs_pkg and cgs_regs are compiled first; drives AXI4-Lite itself.
`timescale 1ns/1ps
`default_nettype none
module cgs_regs_test;
  import cgs_pkg::*;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic                aclk = 1'b0;
  logic                aresetn = 1'b0;
  logic [ADDR_W-1:0]   s_axi_awaddr = '0;
  logic [ADDR_W-1:0]   s_axi_araddr = '0;
  logic [31:0]         s_axi_wdata = '0;
  logic [3:0]          s_axi_wstrb = 4'hf;
  logic                s_axi_awvalid = 1'b0;
  logic                s_axi_wvalid = 1'b0;
  logic                s_axi_arvalid = 1'b0;
  logic                s_axi_bready = 1'b1;
  logic                s_axi_rready = 1'b1;
  logic                s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic                s_axi_arready, s_axi_rvalid;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  logic [31:0]         s_axi_rdata;
  logic [5:0]          adc_gain_code, dac_gain_code;
  logic [2:0]          sidetone_gain_code;
  logic [1:0]          input_buffer_gain_code;
  logic                dac_mute, sidetone_mute;
  logic signed [7:0]   dac_gain_db, sidetone_gain_db;
  logic [7:0]          input_buffer_gain_db;
  int                  error_cnt = 0;
  int                  cmp_count = 0;
  int                  cyc = 0;
  int                  m_adc = 42, m_dac = 42, m_stg = 7, m_input_buffer_gain_code = 0, m_ph = 0;
  int                  i;
  int                  bdb[4] = '{0, 6, 12, 24};

  cgs_regs cgs_regs_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .adc_gain_code, .dac_gain_code,
    .sidetone_gain_code, .input_buffer_gain_code, .dac_mute, .dac_gain_db,
    .sidetone_mute, .sidetone_gain_db, .input_buffer_gain_db);

  always #12.5 aclk = ~aclk;
  // ------------------------------------------------------------------
  // Checks and bus tasks
  // ------------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] st,
                    input logic [1:0] er);
    bit ta, tw, tb;
    logic [1:0] r;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'($urandom), d};
    s_axi_wstrb   <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r  = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!tb);
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      d  = s_axi_rdata;
      r  = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!tr);
    chk("rresp", {30'h0, er}, {30'h0, r});
    chk("rdata", ed, d);
  endtask : rd

  // ------------------------------------------------------------------
  // Model
  // ------------------------------------------------------------------
  task automatic wb(input logic [7:0] d);
    wr(SLOT_ADDR, d, 4'hf, RESP_OKAY);
    case (d[7:6])
      PFX_ADC: m_adc = d[5:0];
      PFX_DAC: m_dac = d[5:0];
      PFX_STB: begin
        m_stg  = d[5:3];
        m_input_buffer_gain_code = d[1:0];
      end
      default: ;
    endcase
  endtask : wb

  task automatic rd_slot;
    logic [7:0] e;
    case (m_ph)
      0: e = {PFX_ADC, 6'(m_adc)};
      1: e = {PFX_DAC, 6'(m_dac)};
      2: e = {PFX_STB, 3'(m_stg), 1'b0, 2'(m_input_buffer_gain_code)};
      default: e = {PFX_VER, VERSION_ID};
    endcase
    rd(SLOT_ADDR, {24'h0, e}, RESP_OKAY);
    m_ph = (m_ph + 1) % 4;
  endtask : rd_slot

  task automatic chk_out;
    chk("adc_code", 32'(m_adc), {26'h0, adc_gain_code});
    chk("dac_code", 32'(m_dac), {26'h0, dac_gain_code});
    chk("dac_mute", 32'(m_dac == 63), {31'h0, dac_mute});
    if (m_dac != 63) chk("dac_db", {24'h0, 8'(m_dac - 42)}, {24'h0, dac_gain_db});
    chk("stg_code", 32'(m_stg), {29'h0, sidetone_gain_code});
    chk("stg_mute", 32'(m_stg == 7), {31'h0, sidetone_mute});
    if (m_stg != 7) chk("stg_db", {24'h0, 8'(-3 - 3 * m_stg)}, {24'h0, sidetone_gain_db});
    chk("input_buffer_gain_code_code", 32'(m_input_buffer_gain_code), {30'h0, input_buffer_gain_code});
    chk("input_buffer_gain_code_db", 32'(bdb[m_input_buffer_gain_code]), {24'h0, input_buffer_gain_db});
  endtask : chk_out

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(32'h8c174278));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_out();
    repeat (5) rd_slot();
    rd(STATUS_ADDR, 32'(m_ph), RESP_OKAY);
    for (i = 0; i < 7; i++) begin
      wb({PFX_DAC, (i == 0) ? 6'h00 : (i == 1) ? 6'h3e : (i == 2) ? 6'h3f : 6'($urandom)});
      chk_out();
    end
    for (i = 0; i < 32; i++) begin
      wb({PFX_STB, 3'(i >> 2), 1'($urandom), 2'(i)});
      chk_out();
    end
    wb({PFX_STB, 3'h5, 1'b1, 2'h2});
    wb({PFX_ADC, 6'($urandom)});
    chk_out();
    wb({PFX_VER, 6'h00});
    chk_out();
    repeat (4) rd_slot();
    wr(SLOT_ADDR, {PFX_DAC, 6'h01}, 4'h0, RESP_OKAY);
    wr(4'h8, {PFX_DAC, 6'h02}, 4'hf, RESP_SLVERR);
    chk_out();
    rd(4'hc, 32'h0, RESP_SLVERR);
    // Mid-run reset brings every code and the read phase back
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    m_adc = 42;
    m_dac = 42;
    m_stg = 7;
    m_input_buffer_gain_code = 0;
    m_ph = 0;
    chk_out();
    repeat (4) rd_slot();
    conclude();
  end
endmodule : cgs_regs_test
`default_nettype wire
